/* File: hdl/lcs_regs.sv */
// How it works
// R1: Ping round trip counted in 40 ns clock units, read at bits 7-15.
// R2: Status bit 16 follows local PHY root state, resets to 0.
// R3: Bit 23 set when a transmit acknowledge has parity or length error.
// R4: Bits 24-27 hold the latest transmit acknowledge code, overwritten each time.
// R5: Bit 31 marks an unread acknowledge; reading the status register clears it.
// R6: Status resets to 1400 0000h; bus reset clears its non-immune fields.
// R7: Control bit 0 set when bus-reset identity results become valid.
// R8: Bit 1 enables self-ID capture; bit 2 picks DMA or log storage.
// R9: Control bit 4 forces busy acknowledges for every incoming packet.
// R10: Control bit 5 enables the link; cleared, no acks, no traffic.
// R11: Writing 1 to bit 10 pulses a flush of async queues only.
// R12: Bit 14 selects pending or error ack for bad packets; bit 15 stores them.
// R13: Bit 16 enables split transactions blocking transmit until response or timeout.
// R14: Bit 17 enables automatic retry on busy acknowledges.
// R15: Bit 18 selects pending or complete ack for write requests.
// R16: Bit 19 selects conflict or busy ack while management agent busy.
// R17: Cycle master needs bit 20 and root; bit 22 runs the offset counter.
// R18: Writing 1 to bit 23 pulses a full DMA block flush.
// R19: Bit 24 accepts stray responses; bit 25 picks DMA or async queue.
// R20: Interrupt bit 0 is OR of masked pending bits; pin is its inverse.
// R21: Masked sources still latch status; reset values kept across bus reset.
// R22: Interrupt on seconds increment, and on two wraps without cycle start.
// R23: Event bits set by hardware, cleared by writing 1, zero writes ignored.
// R24: Host uses only whole 32-bit accesses.
// R25: Reserved bits read zero and ignore writes.
module lcs_regs (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Host register port
  input wire logic [7:0] I_ADDR,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  input wire logic [31:0] I_WDATA,
  output logic [31:0] O_RDATA,
  output logic O_RDATA_VALID,
  output logic O_IRQ_OUT_N,
  // Link core status
  input wire logic I_BUS_RESET,
  input wire logic I_NODE_ID_DONE,
  input wire logic I_PHY_ROOT,
  input wire logic I_PING_SENT,
  input wire logic I_PING_RESP,
  input wire logic I_ACK_RX,
  input wire logic [3:0] I_ACK_CODE,
  input wire logic I_ACK_FAULT,
  input wire logic I_SECOND_TICK,
  input wire logic I_CYCLE_WRAP,
  input wire logic I_CYCLE_START_RX,
  input wire logic [31:0] I_INT_EVENTS,
  // Link core control
  output logic O_SELFID_CAPTURE_EN,
  output logic O_SELFID_DEST_SELECT,
  output logic O_FORCE_BUSY_ALL,
  output logic O_LINK_TXRX_ENABLE,
  output logic O_FAST_ARBITRATION_EN,
  output logic O_ASYNC_TRANSACTION_FLUSH,
  output logic O_BAD_PACKET_PEND_REPLY,
  output logic O_KEEP_BAD_PACKETS,
  output logic O_SPLIT_TXN_ENABLE,
  output logic O_AUTO_RETRY_ENABLE,
  output logic O_WRITE_PEND_REPLY,
  output logic O_MGMT_CONFLICT_REPLY,
  output logic O_CYCLE_MASTER_ACTIVE,
  output logic O_CYCLE_COUNTER_RUN,
  output logic O_DMA_BLOCK_FLUSH,
  output logic O_STRAY_RESPONSE_ACCEPT,
  output logic O_STRAY_RESPONSE_DEST,
  output logic [5:0] O_PRIO_BUDGET
);

  lcs_pkg::lcs_state_t st;
  lcs_pkg::lcs_state_t next_st;

  logic [31:0] misc_view;
  logic [31:0] ctl_view;
  logic [31:0] int_view;
  logic wr_misc;
  logic wr_ctl;
  logic wr_int;
  logic wr_mask;
  logic rd_misc;
  logic rd_ctl;
  logic rd_int;
  logic rd_mask;
  logic [31:0] events;
  logic [31:0] next_view;

  always_comb begin
    misc_view = lcs_pkg::MISC_FIXED;
    misc_view[lcs_pkg::MISC_PING_LSB +: lcs_pkg::MISC_PING_W] = st.ping_val; // see R1
    misc_view[lcs_pkg::MISC_ROOT] = st.root; // see R2
    misc_view[lcs_pkg::MISC_ACK_FAULT] = st.ack_fault;
    misc_view[lcs_pkg::MISC_ACK_LSB +: lcs_pkg::MISC_ACK_W] = st.ack_code;
    misc_view[lcs_pkg::MISC_ACK_UNREAD] = st.ack_unread;
    ctl_view = st.ctl;
    int_view = st.int_stat;
    int_view[lcs_pkg::INT_SUMMARY] = ~st.irq_n; // see R20
  end

  always_comb begin
    wr_misc = 1'b0;
    wr_ctl = 1'b0;
    wr_int = 1'b0;
    wr_mask = 1'b0;
    // Only whole-word accesses exist on this port, so no lane selects. see R24
    if (I_ADDR == lcs_pkg::OFS_MISC) begin
      wr_misc = I_WR_STB;
    end else if (I_ADDR == lcs_pkg::OFS_CTL) begin
      wr_ctl = I_WR_STB;
    end else if (I_ADDR == lcs_pkg::OFS_INT) begin
      wr_int = I_WR_STB;
    end else if (I_ADDR == lcs_pkg::OFS_MASK) begin
      wr_mask = I_WR_STB;
    end
    rd_misc = I_RD_STB && (I_ADDR == lcs_pkg::OFS_MISC);
    rd_ctl = I_RD_STB && (I_ADDR == lcs_pkg::OFS_CTL);
    rd_int = I_RD_STB && (I_ADDR == lcs_pkg::OFS_INT);
    rd_mask = I_RD_STB && (I_ADDR == lcs_pkg::OFS_MASK);
  end

  always_comb begin
    next_st = st;
    events = I_INT_EVENTS & lcs_pkg::INT_SRC_MASK;
    next_view = 32'h00000000;

    // Read data is sampled before this cycle's updates; unmapped reads give zero.
    next_st.rvalid = I_RD_STB;
    if (rd_misc) begin
      next_st.rdata = misc_view;
    end else if (rd_ctl) begin
      next_st.rdata = ctl_view;
    end else if (rd_int) begin
      next_st.rdata = int_view;
    end else if (rd_mask) begin
      next_st.rdata = st.int_mask;
    end else if (I_RD_STB) begin
      next_st.rdata = 32'h00000000;
    end

    // Ping timer: one count per clock, saturating rather than wrapping.
    if (I_PING_SENT) begin
      next_st.ping_run = 1'b1;
      next_st.ping_cnt = 9'h000;
    end else if (st.ping_run && I_PING_RESP) begin
      next_st.ping_run = 1'b0;
      next_st.ping_val = st.ping_cnt; // see R1
    end else if (st.ping_run && (st.ping_cnt != 9'h1ff)) begin
      next_st.ping_cnt = st.ping_cnt + 9'(lcs_pkg::PING_CYCLES_PER_UNIT); // see R1
    end

    next_st.root = I_PHY_ROOT; // see R2

    // A read of the status word clears the unread flag; a new acknowledge wins.
    if (rd_misc) begin
      next_st.ack_unread = 1'b0; // see R5
    end
    if (I_ACK_RX && st.ctl[lcs_pkg::CTL_TXRX_EN]) begin
      next_st.ack_code = I_ACK_CODE; // see R4
      next_st.ack_fault = I_ACK_FAULT; // see R3
      next_st.ack_unread = 1'b1; // see R5
    end

    // Write-one-to-clear with event set winning over the clear.
    if (wr_int) begin
      next_st.int_stat = st.int_stat & ~(I_WDATA & lcs_pkg::INT_SRC_MASK); // see R23
    end

    // Cycle loss: count wraps since the last cycle start.
    if (I_CYCLE_START_RX) begin
      next_st.wraps = 2'h0;
    end else if (I_CYCLE_WRAP) begin
      if (st.wraps + 2'h1 >= lcs_pkg::WRAPS_FOR_LOSS) begin
        events[lcs_pkg::INT_CYCLE_MISSED] = 1'b1; // see R22
        next_st.wraps = 2'h0;
      end else begin
        next_st.wraps = st.wraps + 2'h1;
      end
    end
    if (I_SECOND_TICK) begin
      events[lcs_pkg::INT_SECOND_TICK] = 1'b1; // see R22
    end
    // Masked sources still latch so software can poll them.
    next_st.int_stat = (next_st.int_stat | events) & lcs_pkg::INT_SRC_MASK; // see R21

    if (wr_mask) begin
      next_st.int_mask = I_WDATA & lcs_pkg::MASK_RW_MASK; // see R25
    end

    // Control word; the flush bits never store and read back as zero.
    if (wr_ctl) begin
      next_st.ctl = (st.ctl & ~lcs_pkg::CTL_RW_MASK) | (I_WDATA & lcs_pkg::CTL_RW_MASK); // see R25
    end
    next_st.async_flush = wr_ctl && I_WDATA[lcs_pkg::CTL_ASYNC_FLUSH]; // see R11
    next_st.dma_flush = wr_ctl && I_WDATA[lcs_pkg::CTL_DMA_FLUSH]; // see R18
    if (I_NODE_ID_DONE) begin
      next_st.ctl[lcs_pkg::CTL_ID_VALID] = 1'b1; // see R7
    end

    // Bus reset clears the volatile status and control bit 0; other control and interrupt bits survive it.
    if (I_BUS_RESET) begin
      next_st.ping_val = 9'h000; // see R6
      next_st.ping_run = 1'b0;
      next_st.ack_fault = 1'b0;
      next_st.ack_code = 4'h0;
      next_st.ack_unread = 1'b0;
      next_st.root = 1'b0;
      next_st.ctl[lcs_pkg::CTL_ID_VALID] = 1'b0; // see R7
    end

    // The pin tracks the summary of the words just computed.
    next_view = next_st.int_stat & next_st.int_mask & lcs_pkg::INT_SRC_MASK;
    next_st.irq_n = ~(|next_view); // see R20

    next_st.cyc_master_active = next_st.ctl[lcs_pkg::CTL_CYC_MASTER] && next_st.root; // see R17
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st.ctl <= lcs_pkg::CTL_RESET;
      st.int_stat <= lcs_pkg::INT_RESET;
      st.int_mask <= lcs_pkg::MASK_RESET;
      st.ping_cnt <= 9'h000;
      st.ping_run <= 1'b0;
      st.ping_val <= 9'h000;
      st.root <= 1'b0;
      st.ack_fault <= 1'b0;
      st.ack_code <= 4'h0;
      st.ack_unread <= 1'b0;
      st.wraps <= 2'h0;
      st.rdata <= 32'h00000000;
      st.rvalid <= 1'b0;
      st.irq_n <= 1'b1;
      st.async_flush <= 1'b0;
      st.dma_flush <= 1'b0;
      st.cyc_master_active <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_RDATA_VALID = st.rvalid;
  assign O_IRQ_OUT_N = st.irq_n;
  assign O_SELFID_CAPTURE_EN = st.ctl[lcs_pkg::CTL_SELFID_EN]; // see R8
  assign O_SELFID_DEST_SELECT = st.ctl[lcs_pkg::CTL_SELFID_DEST]; // see R8
  assign O_FORCE_BUSY_ALL = st.ctl[lcs_pkg::CTL_FORCE_BUSY]; // see R9
  assign O_LINK_TXRX_ENABLE = st.ctl[lcs_pkg::CTL_TXRX_EN]; // see R10
  assign O_FAST_ARBITRATION_EN = st.ctl[lcs_pkg::CTL_FAST_ARB];
  assign O_ASYNC_TRANSACTION_FLUSH = st.async_flush; // see R11
  assign O_BAD_PACKET_PEND_REPLY = st.ctl[lcs_pkg::CTL_BAD_PEND]; // see R12
  assign O_KEEP_BAD_PACKETS = st.ctl[lcs_pkg::CTL_KEEP_BAD]; // see R12
  assign O_SPLIT_TXN_ENABLE = st.ctl[lcs_pkg::CTL_SPLIT_EN]; // see R13
  assign O_AUTO_RETRY_ENABLE = st.ctl[lcs_pkg::CTL_RETRY_EN]; // see R14
  assign O_WRITE_PEND_REPLY = st.ctl[lcs_pkg::CTL_WR_PEND]; // see R15
  assign O_MGMT_CONFLICT_REPLY = st.ctl[lcs_pkg::CTL_MGMT_CONFLICT]; // see R16
  assign O_CYCLE_MASTER_ACTIVE = st.cyc_master_active; // see R17
  assign O_CYCLE_COUNTER_RUN = st.ctl[lcs_pkg::CTL_CYC_RUN]; // see R17
  assign O_DMA_BLOCK_FLUSH = st.dma_flush; // see R18
  assign O_STRAY_RESPONSE_ACCEPT = st.ctl[lcs_pkg::CTL_STRAY_ACCEPT]; // see R19
  assign O_STRAY_RESPONSE_DEST = st.ctl[lcs_pkg::CTL_STRAY_DEST]; // see R19
  assign O_PRIO_BUDGET = st.ctl[lcs_pkg::CTL_BUDGET_LSB +: lcs_pkg::CTL_BUDGET_W];

endmodule

/* File: hdl/lcs_pkg.sv */
package lcs_pkg;

  // Register byte offsets on the host register port.
  localparam logic [7:0] OFS_MISC = 8'h04;
  localparam logic [7:0] OFS_CTL = 8'h08;
  localparam logic [7:0] OFS_INT = 8'h0c;
  localparam logic [7:0] OFS_MASK = 8'h10;

  // Reset values.
  localparam logic [31:0] MISC_RESET = 32'h14000000;
  localparam logic [31:0] CTL_RESET = 32'h4400ca00;
  localparam logic [31:0] INT_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h80000000;

  // Fields are printed with bit 0 as the most significant bit, so the
  // vector index of printed bit n is 31 - n.
  // Status bits owned by neighbouring logic read as their reset level here.
  localparam logic [31:0] MISC_FIXED = 32'h14000000;
  localparam int MISC_PING_LSB = 16;
  localparam int MISC_PING_W = 9;
  localparam int MISC_ROOT = 15;
  localparam int MISC_ACK_FAULT = 8;
  localparam int MISC_ACK_LSB = 4;
  localparam int MISC_ACK_W = 4;
  localparam int MISC_ACK_UNREAD = 0;

  localparam int CTL_ID_VALID = 31;
  localparam int CTL_SELFID_EN = 30;
  localparam int CTL_SELFID_DEST = 29;
  localparam int CTL_FORCE_BUSY = 27;
  localparam int CTL_TXRX_EN = 26;
  localparam int CTL_FAST_ARB = 24;
  localparam int CTL_ASYNC_FLUSH = 21;
  localparam int CTL_BAD_PEND = 17;
  localparam int CTL_KEEP_BAD = 16;
  localparam int CTL_SPLIT_EN = 15;
  localparam int CTL_RETRY_EN = 14;
  localparam int CTL_WR_PEND = 13;
  localparam int CTL_MGMT_CONFLICT = 12;
  localparam int CTL_CYC_MASTER = 11;
  localparam int CTL_CYC_RUN = 9;
  localparam int CTL_DMA_FLUSH = 8;
  localparam int CTL_STRAY_ACCEPT = 7;
  localparam int CTL_STRAY_DEST = 6;
  localparam int CTL_BUDGET_LSB = 0;
  localparam int CTL_BUDGET_W = 6;
  localparam logic [31:0] CTL_RW_MASK = 32'h6d03faff;

  localparam int INT_SUMMARY = 31;
  localparam int INT_SECOND_TICK = 18;
  localparam int INT_CYCLE_MISSED = 10;
  localparam logic [31:0] INT_SRC_MASK = 32'h7cfefe00;
  localparam logic [31:0] MASK_RW_MASK = 32'hfcfefe00;

  // One ping unit is one clock period.
  localparam int PING_UNIT_NS = 40;
  localparam int CLK_PERIOD_NS = 40;
  localparam int PING_CYCLES_PER_UNIT = PING_UNIT_NS / CLK_PERIOD_NS;

  // Cycle-timer wraps without a cycle start before the loss flag rises.
  localparam logic [1:0] WRAPS_FOR_LOSS = 2'h2;

  typedef struct packed {
    logic [31:0] ctl;
    logic [31:0] int_stat;
    logic [31:0] int_mask;
    logic [8:0] ping_cnt;
    logic ping_run;
    logic [8:0] ping_val;
    logic root;
    logic ack_fault;
    logic [3:0] ack_code;
    logic ack_unread;
    logic [1:0] wraps;
    logic [31:0] rdata;
    logic rvalid;
    logic irq_n;
    logic async_flush;
    logic dma_flush;
    logic cyc_master_active;
  } lcs_state_t;

endpackage

/* File: dv/lcs_regs_props.sv */
module lcs_regs_props (
  // Watched ports
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_ADDR,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  input wire logic [31:0] I_WDATA,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RDATA_VALID,
  input wire logic O_IRQ_OUT_N,
  input wire logic I_BUS_RESET,
  input wire logic I_PHY_ROOT,
  input wire logic I_ACK_RX,
  input wire logic [3:0] I_ACK_CODE,
  input wire logic O_LINK_TXRX_ENABLE,
  input wire logic O_ASYNC_TRANSACTION_FLUSH,
  input wire logic O_CYCLE_MASTER_ACTIVE,
  input wire logic O_DMA_BLOCK_FLUSH
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  logic rd_misc;
  logic wr_ctl;
  assign rd_misc = I_RD_STB && I_ADDR == 8'h04;
  assign wr_ctl = I_WR_STB && I_ADDR == 8'h08;
  property p_rd_ans; O_RDATA_VALID == $past(I_RD_STB); endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_aflush; O_ASYNC_TRANSACTION_FLUSH == $past(wr_ctl && I_WDATA[21]); endproperty
  a_aflush: assert property (p_aflush) else $error("async flush pulse wrong");
  property p_dflush; O_DMA_BLOCK_FLUSH == $past(wr_ctl && I_WDATA[8]); endproperty
  a_dflush: assert property (p_dflush) else $error("dma flush pulse wrong");
  property p_cm; !$past(I_PHY_ROOT) |-> !O_CYCLE_MASTER_ACTIVE; endproperty
  a_cm: assert property (p_cm) else $error("cycle master without root");
  // The quiet cycle keeps a second acknowledge, an early read or a bus reset out of the check.
  property p_ack; I_ACK_RX && O_LINK_TXRX_ENABLE && !I_BUS_RESET
    ##1 !I_ACK_RX && !I_BUS_RESET && !rd_misc
    ##1 rd_misc |=> O_RDATA[0] && O_RDATA[7:4] == $past(I_ACK_CODE, 3); endproperty
  a_ack: assert property (p_ack) else $error("ack code lost");
  property p_mask0; I_WR_STB && I_ADDR == 8'h10 && I_WDATA == '0 ##1 !I_WR_STB
    |=> O_IRQ_OUT_N; endproperty
  a_mask0: assert property (p_mask0) else $error("masked irq raised");
  property p_unmap; I_RD_STB && !(I_ADDR inside {8'h04, 8'h08, 8'h0c, 8'h10})
    |=> O_RDATA == '0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_txrx; wr_ctl |=> O_LINK_TXRX_ENABLE == $past(I_WDATA[26]); endproperty
  a_txrx: assert property (p_txrx) else $error("link enable not written");
  c_irq: cover property (!O_IRQ_OUT_N);
  c_dflush: cover property (O_DMA_BLOCK_FLUSH);
  c_cm: cover property (O_CYCLE_MASTER_ACTIVE);
endmodule

bind lcs_regs lcs_regs_props i_props (.I_SYS_CLK, .I_RST, .I_ADDR, .I_WR_STB, .I_RD_STB,
  .I_WDATA, .O_RDATA, .O_RDATA_VALID, .O_IRQ_OUT_N, .I_BUS_RESET, .I_PHY_ROOT, .I_ACK_RX,
  .I_ACK_CODE, .O_LINK_TXRX_ENABLE, .O_ASYNC_TRANSACTION_FLUSH, .O_CYCLE_MASTER_ACTIVE,
  .O_DMA_BLOCK_FLUSH);

/* File: dv/lcs_host.sv */
module lcs_host (
  // Clock and answer
  input wire logic i_clk,
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  // Request
  output logic [7:0] o_addr = 8'h00,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [31:0] o_wdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // A missing answer reads as unknown so that it can never match.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rvalid ? i_rdata : 32'hx;
  endtask
endmodule

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, rt, af, irqn, vld, wr, rd, cm;
  logic [19:0] co;
  logic [7:0] ev, addr;
  logic [3:0] code;
  logic [31:0] iev, q, e, w, rdat, wdat;
  int n_mismatch, n_compared, cyc, n;
  lcs_host h (.i_clk(clk), .i_rdata(rdat), .i_rvalid(vld), .o_addr(addr), .o_wr(wr),
    .o_rd(rd), .o_wdata(wdat));
  lcs_regs i_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR_STB(wr), .I_RD_STB(rd),
    .I_WDATA(wdat), .O_RDATA(rdat), .O_RDATA_VALID(vld), .O_IRQ_OUT_N(irqn),
    .I_BUS_RESET(ev[0]), .I_NODE_ID_DONE(ev[1]), .I_PHY_ROOT(rt), .I_PING_SENT(ev[2]),
    .I_PING_RESP(ev[3]), .I_ACK_RX(ev[4]), .I_ACK_CODE(code), .I_ACK_FAULT(af),
    .I_SECOND_TICK(ev[5]), .I_CYCLE_WRAP(ev[6]), .I_CYCLE_START_RX(ev[7]),
    .I_INT_EVENTS(iev), .O_SELFID_CAPTURE_EN(co[19]), .O_SELFID_DEST_SELECT(co[18]),
    .O_FORCE_BUSY_ALL(co[17]), .O_LINK_TXRX_ENABLE(co[16]), .O_FAST_ARBITRATION_EN(co[15]),
    .O_ASYNC_TRANSACTION_FLUSH(), .O_BAD_PACKET_PEND_REPLY(co[14]),
    .O_KEEP_BAD_PACKETS(co[13]), .O_SPLIT_TXN_ENABLE(co[12]), .O_AUTO_RETRY_ENABLE(co[11]),
    .O_WRITE_PEND_REPLY(co[10]), .O_MGMT_CONFLICT_REPLY(co[9]), .O_CYCLE_MASTER_ACTIVE(cm),
    .O_CYCLE_COUNTER_RUN(co[8]), .O_DMA_BLOCK_FLUSH(), .O_STRAY_RESPONSE_ACCEPT(co[7]),
    .O_STRAY_RESPONSE_DEST(co[6]), .O_PRIO_BUDGET(co[5:0]));
  // Control pins in the order of co, taken from a control word.
  function automatic logic [19:0] ctl_pins(input logic [31:0] c);
    return {c[30], c[29], c[27], c[26], c[24], c[17], c[16], c[15], c[14], c[13], c[12], c[9],
      c[7], c[6], c[5:0]};
  endfunction
  task automatic chk(input logic [31:0] g, x);
    n_compared++;
    if (g !== x) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    h.rd(a, q);
    chk(q, x);
  endtask
  task automatic pulse(input int s);
    @(negedge clk);
    ev[s] = 1'b1;
    @(negedge clk);
    ev = 8'h00;
  endtask
  task automatic summarize();
    if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    {rt, af, ev, code, iev} = '0;
    n = $urandom(18);
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rc(8'h04, 32'h14000000);
    rc(8'h08, 32'h4400ca00);
    chk({12'h0, co}, {12'h0, ctl_pins(32'h4400ca00)});
    rc(8'h10, 32'h80000000);
    chk({31'h0, irqn}, 32'h1);
    for (int i = 0; i < 10; i++) begin
      w = (i == 0) ? '1 : $urandom();
      h.wr(8'h08, w);
      rc(8'h08, w & 32'h6d03faff);
      chk({12'h0, co}, {12'h0, ctl_pins(w)});
    end
    h.wr(8'h08, 32'h4400ca00);
    pulse(1);
    rc(8'h08, 32'hc400ca00);
    pulse(0);
    rc(8'h08, 32'h4400ca00);
    rt = 1'b1;
    n = 2 + $urandom_range(40);
    code = 4'($urandom());
    af = 1'b1;
    pulse(2);
    repeat (n - 2) @(negedge clk);
    pulse(3);
    pulse(4);
    e = 32'h14008101 | {7'h0, 9'(n - 1), 16'h0} | {24'h0, code, 4'h0};
    rc(8'h04, e);
    chk({31'h0, cm}, 32'h1);
    h.wr(8'h04, '1);
    rc(8'h04, e & ~32'h1);
    pulse(0);
    rc(8'h04, 32'h14008000);
    h.wr(8'h08, 32'h4000ca00);
    pulse(4);
    rc(8'h04, 32'h14008000);
    h.wr(8'h10, '1);
    rc(8'h10, 32'hfcfefe00);
    e = ($urandom() & 32'h7cfefe00) | 32'h200;
    @(negedge clk);
    iev = e;
    @(negedge clk);
    iev = '0;
    repeat (2) @(negedge clk);
    chk({31'h0, irqn}, 32'h0);
    rc(8'h0c, e | 32'h80000000);
    h.wr(8'h10, '0);
    @(negedge clk);
    chk({31'h0, irqn}, 32'h1);
    rc(8'h0c, e);
    w = e & $urandom();
    h.wr(8'h0c, w);
    rc(8'h0c, e & ~w);
    h.wr(8'h0c, '1);
    pulse(5);
    rc(8'h0c, 32'h40000);
    h.wr(8'h0c, '1);
    pulse(6);
    pulse(7);
    pulse(6);
    rc(8'h0c, 32'h0);
    pulse(6);
    rc(8'h0c, 32'h400);
    rc(8'h20, 32'h0);
    summarize();
  end
endmodule
